// [src/scrr_top.sv]
// Notes on behaviour
// - Every instruction is single-line SPI, eight serial clocks per byte.
// - Readout: opcode, dummy, status, 96-bit tag, 32-bit counter, 256-bit signature.
// - Readout returns the status of the most recent authenticated command frame.
// - Fields are valid after status when last command was a good counter request, not busy.
// - Host may end the readout at any byte by raising chip select.
// - Payload is 49 bytes; anything beyond is arbitrary and discarded by host.
// - While busy, every byte from the third onward repeats status; no fields.
// - Accepted reset aborts operations and restores power-on state and volatile bits.
// - Reset needs reset-enable then reset opcode as consecutive separate instructions.
// - Any opcode other than reset or reset-enable after reset-enable disarms the sequence.
// - After reset the device ignores all commands for about 30 us.
`include "scrr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module scrr_top #(
    parameter int unsigned RST_CYCLES = `SCRR_RST_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // SPI pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Authenticated command engine
    input wire scrr_pkg::scrr_byte_t auth_status,
    input wire logic auth_busy,
    input wire logic auth_error,
    input wire logic auth_last_req,
    input wire logic [`SCRR_TAG_BITS-1:0] auth_tag,
    input wire logic [`SCRR_COUNT_BITS-1:0] auth_counter,
    input wire logic [`SCRR_SIG_BITS-1:0] auth_sig,
    output logic cmd_valid,
    output scrr_pkg::scrr_byte_t cmd_opcode,
    output logic soft_reset,
    output logic recovering
);
    import scrr_pkg::*;
    if (RST_CYCLES < 1 || RST_CYCLES > 511) begin : g_chk
        $error("RST_CYCLES must lie in 1..511");
    end
    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_q;
    logic rst_n;
    logic [2:0] sclk_q;
    logic [2:0] cs_q;
    logic [1:0] mosi_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_q <= 2'h0;
        end else if (ce) begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];
    // Only stages 1 and 2 feed logic; stage 0 is read by stage 1 alone
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 3'h0;
            cs_q <= 3'h7;
            mosi_q <= 2'h0;
        end else if (ce) begin
            sclk_q <= {sclk_q[1:0], spi_sclk};
            cs_q <= {cs_q[1:0], spi_cs_n};
            mosi_q <= {mosi_q[0], spi_mosi};
        end
    end
    logic sclk_rise, sclk_fall, cs_low, cs_rise;
    assign sclk_rise = sclk_q[1] & ~sclk_q[2];
    assign sclk_fall = ~sclk_q[1] & sclk_q[2];
    assign cs_low = ~cs_q[1];
    assign cs_rise = cs_q[1] & ~cs_q[2];
    // ----------------------------------------
    // Bit and byte framing
    // ----------------------------------------
    logic [2:0] bit_q;
    logic [5:0] byte_q;
    scrr_byte_t rx_q;
    scrr_byte_t rx_next;
    logic byte_done;
    assign rx_next = {rx_q[6:0], mosi_q[1]};
    assign byte_done = sclk_rise & cs_low & (bit_q == 3'h7);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= 3'h0;
            byte_q <= 6'h00;
            rx_q <= 8'h00;
        end else if (ce) begin
            if (!cs_low) begin
                bit_q <= 3'h0;
                byte_q <= 6'h00;
            end else if (sclk_rise) begin
                bit_q <= bit_q + 3'h1;
                rx_q <= rx_next;
                if (byte_done && byte_q != `SCRR_BYTE_CNT_MAX) begin
                    byte_q <= byte_q + 6'h01;
                end
            end
        end
    end
    // ----------------------------------------
    // Opcode decode and reset sequence
    // ----------------------------------------
    scrr_phase_e phase_q;
    logic op_taken;
    logic armed_q;
    logic pend_q;
    logic [8:0] rec_q;
    assign op_taken = byte_done & (phase_q == PH_OPCODE) & ~recovering;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_OPCODE;
        end else if (ce) begin
            if (!cs_low) begin
                phase_q <= PH_OPCODE;
            end else if (byte_done) begin
                unique case (phase_q)
                    PH_OPCODE: begin
                        // A command arriving during recovery is swallowed whole
                        if (!recovering && rx_next == `SCRR_OP_READOUT) begin
                            phase_q <= PH_READOUT;
                        end else begin
                            phase_q <= PH_OTHER;
                        end
                    end
                    PH_READOUT: begin
                        phase_q <= PH_READOUT;
                    end
                    PH_OTHER: begin
                        phase_q <= PH_OTHER;
                    end
                endcase
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_opcode <= 8'h00;
        end else if (ce) begin
            cmd_valid <= op_taken;
            if (op_taken) begin
                cmd_opcode <= rx_next;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (ce) begin
            if (soft_reset) begin
                armed_q <= 1'b0;
                pend_q <= 1'b0;
            end else if (op_taken) begin
                armed_q <= (rx_next == `SCRR_OP_RST_EN);
                if (armed_q && rx_next == `SCRR_OP_RST) begin
                    pend_q <= 1'b1;
                end
            end
        end
    end
    // Reset fires when the reset frame closes, so its own bytes are not cut short
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset <= 1'b0;
            recovering <= 1'b0;
            rec_q <= 9'h000;
        end else if (ce) begin
            soft_reset <= pend_q & cs_rise & ~soft_reset;
            if (soft_reset) begin
                recovering <= 1'b1;
                rec_q <= 9'(RST_CYCLES);
            end else if (rec_q != 9'h000) begin
                rec_q <= rec_q - 9'h001;
                if (rec_q == 9'h001) begin
                    recovering <= 1'b0;
                end
            end
        end
    end
    // ----------------------------------------
    // Readout data path
    // ----------------------------------------
    logic busy_snap_q;
    logic valid_snap_q;
    scrr_byte_t status_snap_q;
    scrr_byte_t tx_q;
    scrr_byte_t tx_byte;
    logic tx_load;
    logic [`SCRR_FIELD_BITS-1:0] fields_w;
    logic [5:0] pidx;
    assign fields_w = {auth_tag, auth_counter, auth_sig};
    assign pidx = byte_q - `SCRR_FIRST_FIELD_BYTE;
    assign tx_load = sclk_fall & cs_low & (bit_q == 3'h0) & (phase_q == PH_READOUT) & (byte_q >= `SCRR_STATUS_BYTE);
    // Snapshot at the end of the dummy byte so status and flags share one state; field bytes are read live at each load
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_snap_q <= 1'b0;
            valid_snap_q <= 1'b0;
            status_snap_q <= 8'h00;
        end else if (ce && byte_done && phase_q == PH_READOUT && byte_q == 6'h01) begin
            busy_snap_q <= auth_busy;
            valid_snap_q <= auth_last_req & ~auth_error & ~auth_busy;
            status_snap_q <= auth_status;
        end
    end
    always_comb begin
        if (byte_q == `SCRR_STATUS_BYTE || busy_snap_q) begin
            tx_byte = status_snap_q;
        end else if (valid_snap_q && byte_q < `SCRR_END_BYTE) begin
            tx_byte = fields_w[9'(`SCRR_FIELD_BITS - 8) - {pidx, 3'h0} +: 8];
        end else begin
            tx_byte = 8'h00;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= 8'h00;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else if (ce) begin
            if (!cs_low) begin
                spi_miso_oe <= 1'b0;
                tx_q <= 8'h00;
                spi_miso <= 1'b0;
            end else if (tx_load) begin
                tx_q <= tx_byte;
                spi_miso <= tx_byte[7];
                spi_miso_oe <= 1'b1;
            end else if (sclk_fall) begin
                tx_q <= {tx_q[6:0], 1'b0};
                spi_miso <= tx_q[6];
            end
        end
    end
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [8:0] rec_len_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_len_q <= 9'h000;
        end else if (ce) begin
            rec_len_q <= recovering ? rec_len_q + 9'h001 : 9'h000;
        end
    end
    sequence s_reset_taken;
        soft_reset ##1 (recovering && !armed_q);
    endsequence
    byte_count_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        (sclk_rise && cs_low && byte_q != 6'h3F && $past(byte_q) == byte_q && bit_q != 3'h7) |=> byte_q == $past(byte_q))
        else $error("byte count moved before eight clocks");
    status_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        (tx_load && byte_q == 6'h02) |=> tx_q == status_snap_q)
        else $error("status byte not loaded");
    field_byte_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        (tx_load && !busy_snap_q && valid_snap_q && byte_q == 6'h03) |=> tx_q == auth_tag[95:88])
        else $error("first tag byte wrong");
    busy_repeat_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        (tx_load && busy_snap_q) |=> tx_q == status_snap_q && spi_miso == status_snap_q[7])
        else $error("busy readout did not repeat status");
    past_end_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        (tx_load && !busy_snap_q && byte_q >= 6'h33) |=> tx_q == 8'h00)
        else $error("data past payload not blank");
    cs_release_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        cs_rise |=> !spi_miso_oe && phase_q == PH_OPCODE && byte_q == 6'h00)
        else $error("frame not ended by chip select");
    reset_armed_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        $rose(pend_q) |-> $past(armed_q) && $past(rx_next) == 8'h99)
        else $error("reset pending without enable");
    disarm_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        (op_taken && rx_next != 8'h66) |=> !armed_q)
        else $error("armed state survived other opcode");
    reset_seq_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        soft_reset |-> s_reset_taken)
        else $error("reset did not start recovery");
    recover_len_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        $fell(recovering) |-> $past(rec_len_q) == 9'(RST_CYCLES - 1))
        else $error("recovery length wrong");
    recover_mute_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce)
        recovering |=> !cmd_valid)
        else $error("command accepted during recovery");
endmodule : scrr_top

`default_nettype wire

// [src/scrr_defines.svh]
`ifndef SCRR_DEFINES_SVH
`define SCRR_DEFINES_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SCRR_OP_READOUT 8'h96
`define SCRR_OP_RST_EN 8'h66
`define SCRR_OP_RST 8'h99

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SCRR_BITS_PER_BYTE 8
`define SCRR_STATUS_BYTE 6'h02
`define SCRR_FIRST_FIELD_BYTE 6'h03
`define SCRR_PAYLOAD_BYTES 49
`define SCRR_END_BYTE 6'h33
`define SCRR_BYTE_CNT_MAX 6'h3F
`define SCRR_TAG_BITS 96
`define SCRR_COUNT_BITS 32
`define SCRR_SIG_BITS 256
`define SCRR_FIELD_BITS 384

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCRR_CLK_PERIOD_NS 100
`define SCRR_T_RST_NS 30000
`define SCRR_RST_CYC (`SCRR_T_RST_NS / `SCRR_CLK_PERIOD_NS)

`endif

// [src/scrr_pkg.sv]
package scrr_pkg;
    typedef logic [7:0] scrr_byte_t;
    typedef enum logic [1:0] {PH_OPCODE, PH_READOUT, PH_OTHER} scrr_phase_e;
endpackage : scrr_pkg

// [sim/scrr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module scrr_host_model (
    // Clock
    input wire logic core_clk,
    // SPI pins
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    // ----------------------------------------
    // Received bytes of the last frame
    // ----------------------------------------
    logic [7:0] rx_buf [64];

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // ----------------------------------------
    // One frame: opcode, then zero bytes, cut after nbits
    // ----------------------------------------
    // Clock stands low outside frames; mosi flips after release so no stale level lingers
    task automatic frame(input logic [7:0] op, input int nbits);
        logic [7:0] tx;
        @(posedge core_clk);
        spi_cs_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < nbits; i++) begin
            tx = (i < 8) ? op : 8'h00;
            spi_mosi <= tx[7 - i % 8];
            repeat (4) @(posedge core_clk);
            spi_sclk <= 1'b1;
            rx_buf[i / 8][7 - i % 8] = spi_miso;
            repeat (4) @(posedge core_clk);
            spi_sclk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (8) @(posedge core_clk);
    endtask : frame
endmodule : scrr_host_model

`default_nettype wire

// [sim/scrr_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module scrr_top_tb;
    import scrr_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    // Long recovery so a whole opcode fits inside it
    localparam int unsigned RST_N = 100;
    logic core_clk, resetn, ce, sclk, cs_n, mosi, miso, miso_oe;
    logic busy, err, last_req, cmd_valid, soft_reset, recovering;
    scrr_byte_t st, cmd_opcode;
    logic [95:0] tag;
    logic [31:0] cnt;
    logic [255:0] sig;
    int fails = 0, tests_run = 0, sr_n = 0, cv_n = 0, rec_n = 0, oe_n = 0;

    scrr_top #(.RST_CYCLES(RST_N)) i_scrr_top (.core_clk(core_clk), .resetn(resetn), .ce(ce),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
        .auth_status(st), .auth_busy(busy), .auth_error(err), .auth_last_req(last_req),
        .auth_tag(tag), .auth_counter(cnt), .auth_sig(sig), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .soft_reset(soft_reset), .recovering(recovering));

    scrr_host_model i_scrr_host_model (.core_clk(core_clk), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (soft_reset === 1'b1) begin
            sr_n <= sr_n + 1;
            rec_n <= 0;
        end else if (recovering === 1'b1) begin
            rec_n <= rec_n + 1;
        end
        if (cmd_valid === 1'b1) begin
            cv_n <= cv_n + 1;
        end
        if (miso_oe === 1'b1) begin
            oe_n <= oe_n + 1;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    function automatic logic [7:0] fbyte(input int k);
        logic [383:0] f;
        f = {tag, cnt, sig};
        return f[383 - 8 * (k - 3) -: 8];
    endfunction : fbyte

    task automatic set_eng(input logic [7:0] s, input logic b, input logic e);
        @(posedge core_clk);
        st <= s;
        busy <= b;
        err <= e;
    endtask : set_eng

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_valid;
        set_eng(8'h10, 1'b0, 1'b0);
        i_scrr_host_model.frame(8'h96, 53 * 8);
        check("status", i_scrr_host_model.rx_buf[2], 8'h10);
        for (int k = 3; k < 51; k++) begin
            check("field", i_scrr_host_model.rx_buf[k], fbyte(k));
        end
        check("opcode", cmd_opcode, 8'h96);
        check("past_end", i_scrr_host_model.rx_buf[51], 8'h00);
        last_req <= 1'b0;
        i_scrr_host_model.frame(8'h96, 4 * 8);
        check("no_req_field", i_scrr_host_model.rx_buf[3], 8'h00);
        last_req <= 1'b1;
    endtask : test_valid

    task automatic test_busy;
        set_eng(8'h81, 1'b1, 1'b0);
        i_scrr_host_model.frame(8'h96, 55 * 8);
        for (int k = 2; k < 55; k++) begin
            check("busy_status", i_scrr_host_model.rx_buf[k], 8'h81);
        end
        set_eng(8'h00, 1'b0, 1'b0);
        i_scrr_host_model.frame(8'h96, 4 * 8);
        check("fresh_tag", i_scrr_host_model.rx_buf[3], 8'h01);
    endtask : test_busy

    task automatic test_abort;
        int o0;
        set_eng(8'h24, 1'b0, 1'b1);
        i_scrr_host_model.frame(8'h96, 3 * 8);
        check("err_status", i_scrr_host_model.rx_buf[2], 8'h24);
        o0 = oe_n;
        i_scrr_host_model.frame(8'h96, 20);
        check("oe_on", {7'h00, oe_n != o0}, 8'h01);
        check("oe_off", {7'h00, miso_oe}, 8'h00);
        set_eng(8'h42, 1'b0, 1'b1);
        i_scrr_host_model.frame(8'h96, 51 * 8);
        check("after_abort", i_scrr_host_model.rx_buf[2], 8'h42);
        check("err_field", i_scrr_host_model.rx_buf[3], 8'h00);
    endtask : test_abort

    task automatic test_reset;
        int s0;
        int c0;
        s0 = sr_n;
        set_eng(8'h00, 1'b0, 1'b0);
        i_scrr_host_model.frame(8'h66, 8);
        i_scrr_host_model.frame(8'h99, 8);
        check("reset_taken", 8'(sr_n - s0), 8'h01);
        check("recovering", {7'h00, recovering}, 8'h01);
        c0 = cv_n;
        i_scrr_host_model.frame(8'h66, 8);
        check("ignored", 8'(cv_n - c0), 8'h00);
        for (int w = 0; w < 200 && recovering !== 1'b0; w++) begin
            @(posedge core_clk);
        end
        check("rec_len", 8'(rec_n), 8'(RST_N));
        i_scrr_host_model.frame(8'h99, 8);
        check("lone_reset", 8'(sr_n - s0), 8'h01);
    endtask : test_reset

    task automatic test_disarm;
        int s0;
        s0 = sr_n;
        i_scrr_host_model.frame(8'h66, 8);
        i_scrr_host_model.frame(8'h96, 8);
        i_scrr_host_model.frame(8'h99, 8);
        check("disarmed", 8'(sr_n - s0), 8'h00);
        i_scrr_host_model.frame(8'h66, 8);
        i_scrr_host_model.frame(8'h99, 8);
        check("rearmed", 8'(sr_n - s0), 8'h01);
        repeat (RST_N + 4) @(posedge core_clk);
    endtask : test_disarm

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        st = 8'h00;
        busy = 1'b0;
        err = 1'b0;
        last_req = 1'b1;
        tag = 96'h0102030405060708090A0B0C;
        cnt = 32'h11223344;
        for (int k = 0; k < 32; k++) begin
            sig[255 - 8 * k -: 8] = 8'(8'h40 + k);
        end
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge core_clk);
        test_valid();
        test_busy();
        test_abort();
        test_reset();
        test_disarm();
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        give_verdict();
    end
endmodule : scrr_top_tb

`default_nettype wire
